// file: rtl/arq_pkg.sv
// Constants, field layouts and carrier types for the rule match qualifier.
// Assumes one 40 MHz system clock and the byte-wide indirect register port.
// What this block does
// - Layer 2 code 00 uses count value.
// - Forwarding bit 4 picks us or ms.
// - Bit 3 low: count down, interrupt expiry.
// - Bit 3 high: count matches, interrupt terminal.
// - Layer 2 codes pick type, address, both.
// - Layer 3 code 01 tests IP/protocol.
// - Layer 3 code 10 compares SA/DA.
// - Layer 4 codes: protocol, port, sequence.
// - Side bit: 0 destination, 1 source.
// - Sense bit: 0 unequal, 1 equal.
// - Offset 0x02 holds address byte 47:40.
// - Rule class decodes off, L2, L3, L4.
// - Sixteen entries, first index picks action.
package arq_pkg;
  // Direct register addresses of the indirect access path.
  localparam logic [7:0] ADDR_SELECT = 8'h6e;
  localparam logic [7:0] ADDR_OFFSET = 8'h6f;
  localparam logic [7:0] ADDR_WINDOW = 8'ha0;
  // Indirect byte offsets inside one rule.
  localparam logic [7:0] OFS_FIRST_RULE = 8'h00;
  localparam logic [7:0] OFS_QUALIFIER = 8'h01;
  localparam logic [7:0] OFS_STATION_TOP = 8'h02;
  // Table code in select bits 7:5 and port range in bits 3:0.
  localparam logic [2:0] TABLE_RULES = 3'h2;
  localparam int SEL_TABLE_LSB = 5;
  localparam logic [3:0] PORT_FIRST = 4'h1;
  localparam logic [3:0] PORT_LAST = 4'h5;
  localparam int NUM_PORTS = 5;
  // Reset values of the stored rule bytes.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_FIRST_RULE = 4'h0;
  // Tick timing: 40 MHz clock, one microsecond, one thousand of them per ms.
  localparam int CLOCK_MHZ = 40;
  localparam int TIME_US = 1;
  localparam int US_PER_MS = 1000;
  localparam int US_CYCLES = TIME_US * CLOCK_MHZ;
  localparam logic [5:0] US_LAST = 6'(US_CYCLES - 1);
  localparam logic [9:0] MS_LAST = 10'(US_PER_MS - 1);
  localparam int COUNT_W = 11;

  // Rule class encoding.
  typedef enum logic [1:0] {
    ARQ_CLASS_OFF = 2'b00,
    ARQ_CLASS_L2 = 2'b01,
    ARQ_CLASS_L3 = 2'b10,
    ARQ_CLASS_L4 = 2'b11
  } arq_class_type;

  // Layout of the qualifier byte at offset 0x01.
  typedef struct packed {
    logic [1:0] reserved;
    arq_class_type rule_class;
    logic [1:0] match_field_select;
    logic addr_side;
    logic compare_sense;
  } arq_qual_type;

  // One parsed packet offered for qualification.
  typedef struct packed {
    logic valid;
    logic [3:0] port;
    logic [7:0] sa_top;
    logic [7:0] da_top;
    logic addr_rest_eq;
    logic type_eq;
    logic ip_eq;
    logic proto_eq;
    logic sada_eq;
    logic l4port_eq;
    logic seq_eq;
  } arq_pkt_type;

  // Timer settings taken from the applicable action and forwarding fields.
  typedef struct packed {
    logic [10:0] count_value;
    logic unit_ms;
    logic count_up;
  } arq_action_type;
endpackage

// file: rtl/arq_rule_qualifier.sv
// Per-port rule qualifier: indirect rule byte storage, match evaluation, count timers.
// Assumes the register port and packet inputs are synchronous to clock_i.
`timescale 1ns/100ps
`default_nettype none
module arq_rule_qualifier (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // Byte register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Packet qualification.
  input wire arq_pkg::arq_pkt_type pkt_i,
  input wire arq_pkg::arq_action_type action_i,
  output logic match_o,
  output logic [3:0] match_port_o,
  output logic [3:0] first_rule_index_o,
  // Count timer events, one bit per port.
  output logic [arq_pkg::NUM_PORTS-1:0] timer_irq_o
);
  localparam int NP = arq_pkg::NUM_PORTS;
  localparam int CW = arq_pkg::COUNT_W;

  // Reset synchroniser; the first stage feeds only the second.
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rstn = rst_sync_reg;

  // Direct registers and stored rule bytes.
  logic [7:0] select_reg, select_next;
  logic [7:0] offset_reg, offset_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [3:0] first_rule_reg [NP];
  logic [3:0] first_rule_next [NP];
  arq_pkg::arq_qual_type qual_reg [NP];
  arq_pkg::arq_qual_type qual_next [NP];
  logic [7:0] station_reg [NP];
  logic [7:0] station_next [NP];

  // Decode of the window target; only ports 1..5 of the rule table are reachable.
  logic win_ok;
  logic [2:0] win_idx;
  always_comb begin
    win_ok = (select_reg[7:arq_pkg::SEL_TABLE_LSB] == arq_pkg::TABLE_RULES) &&
             (select_reg[3:0] >= arq_pkg::PORT_FIRST) &&
             (select_reg[3:0] <= arq_pkg::PORT_LAST);
    win_idx = 3'(select_reg[3:0] - arq_pkg::PORT_FIRST);
  end

  // Register writes and read data. Reads of unmapped addresses return zero.
  always_comb begin
    select_next = select_reg;
    offset_next = offset_reg;
    rdata_next = rdata_reg;
    first_rule_next = first_rule_reg;
    qual_next = qual_reg;
    station_next = station_reg;
    if (reg_wr_i) begin
      if (reg_addr_i == arq_pkg::ADDR_SELECT) begin
        select_next = reg_wdata_i;
      end else if (reg_addr_i == arq_pkg::ADDR_OFFSET) begin
        offset_next = reg_wdata_i;
      end else if (reg_addr_i == arq_pkg::ADDR_WINDOW && win_ok) begin
        if (offset_reg == arq_pkg::OFS_FIRST_RULE) begin
          first_rule_next[win_idx] = reg_wdata_i[3:0];
        end else if (offset_reg == arq_pkg::OFS_QUALIFIER) begin
          // Reserved bits 7:6 are never stored, so they read back as zero.
          qual_next[win_idx] = arq_pkg::arq_qual_type'({2'b00, reg_wdata_i[5:0]});
        end else if (offset_reg == arq_pkg::OFS_STATION_TOP) begin
          station_next[win_idx] = reg_wdata_i;
        end
      end
    end
    if (reg_rd_i) begin
      rdata_next = 8'h00;
      if (reg_addr_i == arq_pkg::ADDR_SELECT) begin
        rdata_next = select_reg;
      end else if (reg_addr_i == arq_pkg::ADDR_OFFSET) begin
        rdata_next = offset_reg;
      end else if (reg_addr_i == arq_pkg::ADDR_WINDOW && win_ok) begin
        if (offset_reg == arq_pkg::OFS_FIRST_RULE) begin
          rdata_next = {4'h0, first_rule_reg[win_idx]};
        end else if (offset_reg == arq_pkg::OFS_QUALIFIER) begin
          rdata_next = qual_reg[win_idx];
        end else if (offset_reg == arq_pkg::OFS_STATION_TOP) begin
          rdata_next = station_reg[win_idx];
        end
      end
    end
  end

  // Register state; the qualifier fields come out of reset at zero.
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      select_reg <= arq_pkg::RST_BYTE;
      offset_reg <= arq_pkg::RST_BYTE;
      rdata_reg <= arq_pkg::RST_BYTE;
      for (int i = 0; i < NP; i++) begin
        first_rule_reg[i] <= arq_pkg::RST_FIRST_RULE;
        qual_reg[i] <= arq_pkg::arq_qual_type'(arq_pkg::RST_BYTE);
        station_reg[i] <= arq_pkg::RST_BYTE;
      end
    end else begin
      select_reg <= select_next;
      offset_reg <= offset_next;
      rdata_reg <= rdata_next;
      first_rule_reg <= first_rule_next;
      qual_reg <= qual_next;
      station_reg <= station_next;
    end
  end
  assign reg_rdata_o = rdata_reg;

  // Match evaluation for the packet's own port.
  logic pkt_ok;
  logic [2:0] pkt_idx;
  arq_pkg::arq_qual_type pq;
  logic addr_eq;
  logic field_eq;
  logic code_ok;
  logic hit;
  always_comb begin
    pkt_ok = pkt_i.valid && (pkt_i.port >= arq_pkg::PORT_FIRST) &&
             (pkt_i.port <= arq_pkg::PORT_LAST);
    pkt_idx = 3'(pkt_i.port - arq_pkg::PORT_FIRST);
    pq = pkt_ok ? qual_reg[pkt_idx] : arq_pkg::arq_qual_type'(arq_pkg::RST_BYTE);
    addr_eq = ((pq.addr_side ? pkt_i.sa_top : pkt_i.da_top) == station_reg[pkt_idx]) &&
              pkt_i.addr_rest_eq;
    field_eq = 1'b0;
    code_ok = 1'b1;
    unique case (pq.rule_class)
      arq_pkg::ARQ_CLASS_OFF: begin
        // A disabled rule never matches and takes no action.
        code_ok = 1'b0;
      end
      arq_pkg::ARQ_CLASS_L2: begin
        unique case (pq.match_field_select)
          2'b01: field_eq = pkt_i.type_eq;
          2'b10: field_eq = addr_eq;
          default: field_eq = addr_eq && pkt_i.type_eq;
        endcase
      end
      arq_pkg::ARQ_CLASS_L3: begin
        unique case (pq.match_field_select)
          2'b01: field_eq = pkt_i.ip_eq || pkt_i.proto_eq;
          2'b10: field_eq = pkt_i.sada_eq;
          default: code_ok = 1'b0;
        endcase
      end
      arq_pkg::ARQ_CLASS_L4: begin
        unique case (pq.match_field_select)
          2'b00: field_eq = pkt_i.proto_eq;
          2'b11: field_eq = pkt_i.seq_eq;
          default: field_eq = pkt_i.l4port_eq;
        endcase
      end
    endcase
    hit = pkt_ok && code_ok && (pq.compare_sense ? field_eq : !field_eq);
  end

  // Match result registers.
  logic match_reg, match_next;
  logic [3:0] mport_reg, mport_next;
  logic [3:0] mfirst_reg, mfirst_next;
  always_comb begin
    match_next = hit;
    mport_next = hit ? pkt_i.port : mport_reg;
    mfirst_next = hit ? first_rule_reg[pkt_idx] : mfirst_reg;
  end
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      match_reg <= 1'b0;
      mport_reg <= 4'h0;
      mfirst_reg <= arq_pkg::RST_FIRST_RULE;
    end else begin
      match_reg <= match_next;
      mport_reg <= mport_next;
      mfirst_reg <= mfirst_next;
    end
  end
  assign match_o = match_reg;
  assign match_port_o = mport_reg;
  assign first_rule_index_o = mfirst_reg;

  // Time base: a prescaler gives the microsecond tick, a second counter the ms tick.
  logic [5:0] us_cnt_reg, us_cnt_next;
  logic [9:0] ms_cnt_reg, ms_cnt_next;
  logic us_tick, ms_tick;
  always_comb begin
    us_tick = (us_cnt_reg == arq_pkg::US_LAST);
    ms_tick = us_tick && (ms_cnt_reg == arq_pkg::MS_LAST);
    us_cnt_next = us_tick ? 6'h00 : us_cnt_reg + 6'h01;
    ms_cnt_next = ms_cnt_reg;
    if (us_tick) begin
      ms_cnt_next = ms_tick ? 10'h000 : ms_cnt_reg + 10'h001;
    end
  end
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      us_cnt_reg <= 6'h00;
      ms_cnt_reg <= 10'h000;
    end else begin
      us_cnt_reg <= us_cnt_next;
      ms_cnt_reg <= ms_cnt_next;
    end
  end

  // Count timers, one per port, active only for Layer 2 rules with code 00.
  // A hit on the port restarts the down counter, so expiry means no hit for the whole period.
  logic [CW-1:0] cnt_reg [NP];
  logic [CW-1:0] cnt_next [NP];
  logic [NP-1:0] run_reg, run_next;
  logic [NP-1:0] irq_reg, irq_next;
  logic unit_tick;
  always_comb begin
    unit_tick = action_i.unit_ms ? ms_tick : us_tick;
    cnt_next = cnt_reg;
    run_next = run_reg;
    irq_next = '0;
    for (int i = 0; i < NP; i++) begin
      if (qual_reg[i].rule_class != arq_pkg::ARQ_CLASS_L2 ||
          qual_reg[i].match_field_select != 2'b00) begin
        cnt_next[i] = '0;
        run_next[i] = 1'b0;
      end else if (action_i.count_up) begin
        run_next[i] = 1'b0;
        if (hit && pkt_idx == 3'(i)) begin
          if (cnt_reg[i] + 11'h001 >= action_i.count_value) begin
            irq_next[i] = 1'b1;
            cnt_next[i] = '0;
          end else begin
            cnt_next[i] = cnt_reg[i] + 11'h001;
          end
        end
      end else begin
        if (hit && pkt_idx == 3'(i)) begin
          cnt_next[i] = action_i.count_value;
          run_next[i] = 1'b1;
        end else if (run_reg[i] && unit_tick) begin
          if (cnt_reg[i] <= 11'h001) begin
            irq_next[i] = 1'b1;
            cnt_next[i] = '0;
            run_next[i] = 1'b0;
          end else begin
            cnt_next[i] = cnt_reg[i] - 11'h001;
          end
        end
      end
    end
  end
  always_ff @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NP; i++) begin
        cnt_reg[i] <= '0;
      end
      run_reg <= '0;
      irq_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      irq_reg <= irq_next;
    end
  end
  assign timer_irq_o = irq_reg;
endmodule
`default_nettype wire

// file: verification/arq_rule_qualifier_props.sv
// Port checker for the rule qualifier: register window, match path, timer events.
// Assumes it is bound onto arq_rule_qualifier and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none
module arq_rule_qualifier_props (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Packet and timer side.
  input wire arq_pkg::arq_pkt_type pkt_i,
  input wire arq_pkg::arq_action_type action_i,
  input wire logic match_o,
  input wire logic [3:0] match_port_o,
  input wire logic [3:0] first_rule_index_o,
  input wire logic [arq_pkg::NUM_PORTS-1:0] timer_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Shadow copies of select and offset, so refused window reads can be judged.
  logic [7:0] sel_reg, sel_next, ofs_reg, ofs_next;
  logic win_bad;
  always_comb begin
    sel_next = (reg_wr_i && reg_addr_i == arq_pkg::ADDR_SELECT) ? reg_wdata_i : sel_reg;
    ofs_next = (reg_wr_i && reg_addr_i == arq_pkg::ADDR_OFFSET) ? reg_wdata_i : ofs_reg;
    win_bad = sel_reg[7:5] != arq_pkg::TABLE_RULES || sel_reg[3:0] < arq_pkg::PORT_FIRST
      || sel_reg[3:0] > arq_pkg::PORT_LAST || ofs_reg > arq_pkg::OFS_STATION_TOP;
  end
  // Registers only; the shadow follows the design's reset.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_reg <= 8'h00;
      ofs_reg <= 8'h00;
    end else begin
      sel_reg <= sel_next;
      ofs_reg <= ofs_next;
    end
  end
  // A read of the data window, and a zero answer one cycle on.
  sequence win_rd_s;
    reg_rd_i && reg_addr_i == arq_pkg::ADDR_WINDOW;
  endsequence
  sequence zero_rd_s;
    ##1 reg_rdata_o == 8'h00;
  endsequence
  match_cause_a: assert property (match_o |-> $past(pkt_i.valid) && $past(pkt_i.port) inside {[1:5]})
    else $error("match without a packet on a valid port");
  match_port_a: assert property (match_o |-> match_port_o == $past(pkt_i.port))
    else $error("match port differs from packet port");
  port_hold_a: assert property (!match_o |-> $stable(match_port_o) && $stable(first_rule_index_o))
    else $error("match outputs moved without a match");
  rdata_hold_a: assert property ($changed(reg_rdata_o) |-> $past(reg_rd_i))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd_i && !(reg_addr_i inside {8'h6e, 8'h6f, 8'ha0}) |-> zero_rd_s)
    else $error("unmapped read not zero");
  win_refuse_a: assert property (win_rd_s ##0 win_bad |-> zero_rd_s)
    else $error("refused window read not zero");
  qual_rsvd_a: assert property (win_rd_s ##0 (!win_bad && ofs_reg == 8'h01) |=> reg_rdata_o[7:6] == 2'b00)
    else $error("qualifier reserved bits not zero");
  irq_cause_a: assert property (|timer_irq_o && $past(action_i.count_up) |-> $past(pkt_i.valid) && timer_irq_o == 5'h01 << ($past(pkt_i.port) - 4'h1))
    else $error("count-up event without a hit on that port");
endmodule
bind arq_rule_qualifier arq_rule_qualifier_props props_u (.clock_i(clock_i),
  .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pkt_i(pkt_i), .action_i(action_i),
  .match_o(match_o), .match_port_o(match_port_o), .first_rule_index_o(first_rule_index_o),
  .timer_irq_o(timer_irq_o));
`default_nettype wire

// file: verification/arq_rule_qualifier_tb.sv
// Self-checking bench for the rule qualifier through its byte register port.
// Assumes the package, the design and its bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module arq_rule_qualifier_tb;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  arq_pkg::arq_pkt_type pk = '0;
  arq_pkg::arq_action_type act = '0;
  logic match;
  logic [3:0] mport, fri;
  logic [4:0] irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  // The 40 MHz clock.
  always #12.5 clock_i = ~clock_i;
  arq_rule_qualifier dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wr_i(we), .reg_rd_i(re), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pkt_i(pk),
    .action_i(act), .match_o(match), .match_port_o(mport), .first_rule_index_o(fri),
    .timer_irq_o(irq));
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One write strobe, taken at the second edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clock_i);
    we <= 1'b0;
  endtask
  // Read data holds, so it is sampled one edge after the answer.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clock_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clock_i);
    re <= 1'b0;
    @(posedge clock_i);
    #1 cmp(what, {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic sel(input logic [3:0] p, input logic [7:0] o);
    wr(arq_pkg::ADDR_SELECT, {arq_pkg::TABLE_RULES, 1'b0, p});
    wr(arq_pkg::ADDR_OFFSET, o);
  endtask
  // A packet pulse; d picks whether the destination or the source byte is 0x5a.
  task automatic send(input logic [3:0] p, input logic [6:0] f, input logic d);
    @(posedge clock_i);
    pk <= {1'b1, p, d ? 8'ha5 : 8'h5a, d ? 8'h5a : 8'ha5, f};
    @(posedge clock_i);
    pk.valid <= 1'b0;
    #1;
  endtask
  task automatic chk_m(input logic [7:0] q, input logic [6:0] f, input logic d, input logic e);
    wr(arq_pkg::ADDR_WINDOW, q);
    send(4'h2, f, d);
    cmp("match", {15'h0000, e}, {15'h0000, match});
    if (e) cmp("rule index", 16'h0009, {12'h000, fri});
    if (e) cmp("match port", 16'h0002, {12'h000, mport});
  endtask
  // Cycle ceiling, above the two timer waits of about 80100 cycles.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int o = 0; o < 3; o++) begin
      sel(4'h1, 8'(o));
      rd(arq_pkg::ADDR_WINDOW, 8'h00, "reset byte");
    end
    sel(4'h3, 8'h02);
    wr(arq_pkg::ADDR_WINDOW, 8'h5a);
    rd(arq_pkg::ADDR_WINDOW, 8'h5a, "station byte");
    sel(4'h1, 8'h02);
    rd(arq_pkg::ADDR_WINDOW, 8'h00, "other port");
    wr(arq_pkg::ADDR_SELECT, 8'h23);
    rd(arq_pkg::ADDR_WINDOW, 8'h00, "wrong table");
    sel(4'h6, 8'h02);
    rd(arq_pkg::ADDR_WINDOW, 8'h00, "port six");
    rd(8'h10, 8'h00, "unmapped");
    sel(4'h2, 8'h01);
    wr(arq_pkg::ADDR_WINDOW, 8'hff);
    rd(arq_pkg::ADDR_WINDOW, 8'h3f, "qualifier");
    $display("test registers done");
    sel(4'h2, 8'h00);
    wr(arq_pkg::ADDR_WINDOW, 8'h09);
    sel(4'h2, 8'h02);
    wr(arq_pkg::ADDR_WINDOW, 8'h5a);
    sel(4'h2, 8'h01);
    chk_m(8'h15, 7'h20, 1'b1, 1'b1);
    chk_m(8'h15, 7'h00, 1'b1, 1'b0);
    chk_m(8'h14, 7'h00, 1'b1, 1'b1);
    chk_m(8'h19, 7'h40, 1'b1, 1'b1);
    chk_m(8'h19, 7'h40, 1'b0, 1'b0);
    chk_m(8'h1b, 7'h40, 1'b0, 1'b1);
    chk_m(8'h1d, 7'h60, 1'b1, 1'b1);
    chk_m(8'h1d, 7'h40, 1'b1, 1'b0);
    chk_m(8'h25, 7'h10, 1'b1, 1'b1);
    chk_m(8'h25, 7'h08, 1'b1, 1'b1);
    chk_m(8'h25, 7'h00, 1'b1, 1'b0);
    chk_m(8'h29, 7'h04, 1'b1, 1'b1);
    chk_m(8'h28, 7'h04, 1'b1, 1'b0);
    chk_m(8'h31, 7'h08, 1'b1, 1'b1);
    chk_m(8'h31, 7'h04, 1'b1, 1'b0);
    chk_m(8'h35, 7'h02, 1'b1, 1'b1);
    chk_m(8'h39, 7'h02, 1'b1, 1'b1);
    chk_m(8'h3d, 7'h01, 1'b1, 1'b1);
    chk_m(8'h3d, 7'h02, 1'b1, 1'b0);
    chk_m(8'h11, 7'h40, 1'b1, 1'b0);
    chk_m(8'h20, 7'h00, 1'b1, 1'b0);
    chk_m(8'h2c, 7'h00, 1'b1, 1'b0);
    chk_m(8'h05, 7'h20, 1'b1, 1'b0);
    $display("test match done");
    @(posedge clock_i);
    act <= {11'd3, 1'b0, 1'b1};
    sel(4'h4, 8'h02);
    wr(arq_pkg::ADDR_WINDOW, 8'h5a);
    sel(4'h4, 8'h01);
    wr(arq_pkg::ADDR_WINDOW, 8'h11);
    for (int i = 0; i < 3; i++) begin
      send(4'h4, 7'h60, 1'b1);
      cmp("count up irq", i == 2 ? 16'h0008 : 16'h0000, {11'h000, irq});
    end
    $display("test count up done");
    for (int u = 0; u < 2; u++) begin
      @(posedge clock_i);
      act <= {11'd2, u[0], 1'b0};
      repeat (100) @(posedge clock_i);
      send(4'h4, 7'h60, 1'b1);
      n = 0;
      while (irq !== 5'h08 && n < 81000) begin
        @(posedge clock_i);
        #1 n++;
      end
      cmp("down wait", 16'h0001, {15'h0000, n >= (u ? 40000 : 40) && n <= (u ? 80050 : 82)});
    end
    $display("test count down done");
    close_out();
  end
endmodule
`default_nettype wire
